// file: ssg_defs.svh
// Timing counts and field positions for the speed sensor fault and pulse guard.
`ifndef SSG_DEFS_SVH
`define SSG_DEFS_SVH
`define SSG_CLK_MHZ 200
`define SSG_HOLD_US 1000
`define SSG_HOLD_MARGIN_US 100
`define SSG_HOLD_CYC ((`SSG_HOLD_US + `SSG_HOLD_MARGIN_US) * `SSG_CLK_MHZ)
`define SSG_PULSE_CYC 200
`define SSG_MON_W 8
`define SSG_RECOV_MASK 8'h0f
`define SSG_RECAL_RATIO 2
`define SSG_AMP_W 12
`endif

// file: ssg_pkg.sv
// Types shared by the speed sensor fault and pulse guard.
package ssg_pkg;
   typedef enum logic [1:0] {SsgRun, SsgFault, SsgRstCtl} ssg_state_t;
   typedef enum logic [1:0] {SsgProtoSpeed, SsgProtoPulse, SsgProtoXor}
      ssg_proto_t;
endpackage : ssg_pkg

// file: ssg_pulse_if.sv
// Carrier between the top and the pulse guard.
`timescale 1ns/100ps
interface ssg_pulse_if;
   logic reqA;
   logic reqB;
   logic pulseMode;
   logic outA;
   logic outB;
   logic busy;
   modport top (output reqA, output reqB, output pulseMode,
      input outA, input outB, input busy);
   modport guard (input reqA, input reqB, input pulseMode,
      output outA, output outB, output busy);
endinterface : ssg_pulse_if

// file: ssg_pulse_guard.sv
// Pulse guard that keeps a started output pulse from being truncated.
`timescale 1ns/100ps
`include "ssg_defs.svh"
module ssg_pulse_guard
   import ssg_pkg::*;
(
   // Clock and reset.
   input wire logic clock,
   input wire logic rst_n,
   // Carrier.
   ssg_pulse_if.guard pg
);
   typedef struct packed {
      logic outA;
      logic outB;
      logic [15:0] cnt;
   } ssg_pg_t;
   ssg_pg_t st_r, st_nxt;

   assign pg.outA = st_r.outA;
   assign pg.outB = st_r.outB;
   assign pg.busy = pg.pulseMode && (st_r.cnt != 16'h0000);

   always_comb begin
      st_nxt = st_r;
      if (st_r.cnt != 16'h0000) begin
         st_nxt.cnt = st_r.cnt - 16'h0001;
      end
      if (!pg.busy) begin
         if (pg.reqA != st_r.outA || pg.reqB != st_r.outB) begin
            st_nxt.outA = pg.reqA;
            st_nxt.outB = pg.reqB;
            st_nxt.cnt = 16'(`SSG_PULSE_CYC);
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   pulse_hold_a: assert property (@(posedge clock)
      disable iff (!rst_n)
      pg.busy |=> $stable(pg.outA) && $stable(pg.outB))
      else $error("output changed during a pulse");
   nonpulse_free_a: assert property (@(posedge clock)
      disable iff (!rst_n)
      !pg.pulseMode |=> pg.outA == $past(pg.reqA) &&
      pg.outB == $past(pg.reqB))
      else $error("guard blocked outside pulse mode");
endmodule : ssg_pulse_guard

// file: ssg_fault_guard.sv
// Top of the speed sensor fault supervision and pulse guard.
`timescale 1ns/100ps
`include "ssg_defs.svh"
module ssg_fault_guard
   import ssg_pkg::*;
#(
   parameter int unsigned HOLD_CYC = `SSG_HOLD_CYC
)
(
   // Clock and reset.
   input wire logic clock,
   input wire logic rst_n,
   // Diagnostics and configuration.
   input wire logic [`SSG_MON_W-1:0] monFire,
   input wire ssg_proto_t protocol,
   // Signal path.
   input wire logic speedA,
   input wire logic speedB,
   input wire logic calibrated,
   input wire logic [`SSG_AMP_W-1:0] liveAmp,
   input wire logic [`SSG_AMP_W-1:0] calAmp,
   // Controller actions.
   output logic ctlReset,
   output logic recalibrate,
   output logic faultActive,
   // Output drivers, high means fault-high level.
   output logic outA,
   output logic outB,
   output logic faultHigh
);
   typedef struct packed {
      ssg_state_t state;
      logic [31:0] holdCnt;
      logic recov;
      logic ctlReset;
      logic recal;
   } ssg_top_t;
   ssg_top_t st_r, st_nxt;
   ssg_pulse_if pg();

   function automatic logic isRecov(input logic [`SSG_MON_W-1:0] m);
      return (m & `SSG_MON_W'(`SSG_RECOV_MASK)) != '0 &&
         (m & ~`SSG_MON_W'(`SSG_RECOV_MASK)) == '0;
   endfunction : isRecov

   function automatic logic ampLarge(input logic [`SSG_AMP_W-1:0] live,
         input logic [`SSG_AMP_W-1:0] cal);
      return {1'b0, live} >
         (`SSG_AMP_W+1)'(cal) * (`SSG_AMP_W+1)'(`SSG_RECAL_RATIO);
   endfunction : ampLarge

   assign pg.reqA = speedA;
   assign pg.reqB = speedB;
   assign pg.pulseMode = (protocol == SsgProtoPulse);

   ssg_pulse_guard u_guard (
      .clock(clock),
      .rst_n(rst_n),
      .pg(pg)
   );

   always_comb begin
      st_nxt = st_r;
      st_nxt.ctlReset = 1'b0;
      st_nxt.recal = 1'b0;
      if (calibrated && st_r.state == SsgRun &&
          ampLarge(liveAmp, calAmp)) begin
         st_nxt.recal = 1'b1;
      end
      case (st_r.state)
         SsgRun: begin
            if (monFire != '0) begin
               st_nxt.state = SsgFault;
               st_nxt.holdCnt = '0;
               st_nxt.recov = isRecov(monFire);
            end
         end
         SsgFault: begin
            if (st_r.holdCnt < HOLD_CYC) begin
               st_nxt.holdCnt = st_r.holdCnt + 32'h1;
            end else if (monFire != '0 && !isRecov(monFire)) begin
               st_nxt.recov = 1'b0;
            end else if (st_r.recov) begin
               st_nxt.state = SsgRstCtl;
               st_nxt.ctlReset = 1'b1;
            end else if (monFire == '0 && !st_r.recov) begin
               st_nxt.holdCnt = st_r.holdCnt;
            end
         end
         SsgRstCtl: begin
            st_nxt.state = SsgRun;
            st_nxt.recov = 1'b0;
         end
         default: begin
            st_nxt.state = SsgRun;
         end
      endcase
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '{state: SsgRun, holdCnt: 32'h0, recov: 1'b0,
            ctlReset: 1'b0, recal: 1'b0};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign faultActive = (st_r.state != SsgRun);
   assign faultHigh = faultActive;
   assign outA = faultActive ? 1'b1 : pg.outA;
   assign outB = faultActive ? 1'b1 : pg.outB;
   assign ctlReset = st_r.ctlReset;
   assign recalibrate = st_r.recal;

   fault_entry_a: assert property (@(posedge clock)
      disable iff (!rst_n)
      (st_r.state == SsgRun && monFire != '0) |=> faultActive)
      else $error("monitor did not raise fault");
   both_high_a: assert property (@(posedge clock)
      disable iff (!rst_n)
      faultActive |-> outA && outB && faultHigh)
      else $error("fault not on both outputs");
   hold_long_a: assert property (@(posedge clock)
      disable iff (!rst_n)
      (st_r.state == SsgFault && st_r.holdCnt < HOLD_CYC) |=> faultActive)
      else $error("fault released before hold expired");
   hold_count_a: assert property (@(posedge clock)
      disable iff (!rst_n)
      (st_r.state == SsgFault && st_r.holdCnt < HOLD_CYC) |=>
      st_r.holdCnt == $past(st_r.holdCnt) + 32'h1)
      else $error("hold counter did not advance");
   reset_after_a: assert property (@(posedge clock)
      disable iff (!rst_n)
      ctlReset |-> $past(st_r.holdCnt) >= HOLD_CYC)
      else $error("controller reset before hold expired");
   auto_reset_a: assert property (@(posedge clock)
      disable iff (!rst_n)
      (st_r.state == SsgFault && st_r.recov && st_r.holdCnt >= HOLD_CYC
      && (monFire == '0 || isRecov(monFire))) |=> ctlReset)
      else $error("no automatic controller reset");
   ctl_single_a: assert property (@(posedge clock)
      disable iff (!rst_n)
      ctlReset |=> !ctlReset && !faultActive)
      else $error("controller reset not a single pulse");
   idle_no_reset_a: assert property (@(posedge clock)
      disable iff (!rst_n)
      !faultActive |-> !ctlReset)
      else $error("controller reset without a fault");
   fatal_stay_a: assert property (@(posedge clock)
      disable iff (!rst_n)
      ctlReset |-> $past(st_r.recov))
      else $error("reset issued for a fatal fault");
   fatal_hold_a: assert property (@(posedge clock)
      disable iff (!rst_n)
      (st_r.state == SsgFault && !st_r.recov) |=>
      faultActive)
      else $error("fatal fault released");
   run_entry_a: assert property (@(posedge clock)
      disable iff (!rst_n)
      (st_r.state == SsgRun && monFire != '0) |=>
      st_r.recov == isRecov($past(monFire)))
      else $error("recoverable class wrong on fault entry");
   one_ms_a: assert property (@(posedge clock)
      disable iff (!rst_n)
      $fell(faultActive) |-> $past(st_r.state) == SsgRstCtl)
      else $error("fault released without full hold");
   recal_a: assert property (@(posedge clock)
      disable iff (!rst_n)
      (calibrated && !faultActive && ampLarge(liveAmp, calAmp))
      |=> recalibrate)
      else $error("recalibration missed");
   recal_quiet_a: assert property (@(posedge clock)
      disable iff (!rst_n)
      (!calibrated || faultActive) |=> !recalibrate)
      else $error("recalibration without calibration or during fault");
   pin_hold_a: assert property (@(posedge clock)
      disable iff (!rst_n)
      (pg.busy && !faultActive) ##1 !faultActive |->
      $stable(outA) && $stable(outB))
      else $error("pin changed during a pulse");
   speed_follow_a: assert property (@(posedge clock)
      disable iff (!rst_n)
      !pg.pulseMode ##1 !faultActive |->
      outA == $past(speedA) && outB == $past(speedB))
      else $error("pin did not follow speed outside pulse mode");
   no_spur_a: assert property (@(posedge clock)
      disable iff (!rst_n)
      (!faultActive && monFire == '0) |=> !faultActive)
      else $error("spurious fault");
endmodule : ssg_fault_guard

// file: ssg_ctl_model.sv
// Controller model that watches both sensor outputs for a held fault.
`timescale 1ns/100ps
module ssg_ctl_model #(
   parameter int unsigned SEEN_CYC = 40
)
(
   // Clock and reset.
   input wire logic clock,
   input wire logic rst_n,
   // Sensor outputs.
   input wire logic outA,
   input wire logic outB,
   // Fault report.
   output logic faultSeen
);
   int unsigned highCnt_r;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         highCnt_r <= 0;
         faultSeen <= 1'b0;
      end else if (outA && outB) begin
         highCnt_r <= highCnt_r + 1;
         faultSeen <= faultSeen | (highCnt_r >= SEEN_CYC);
      end else begin
         highCnt_r <= 0;
      end
   end
endmodule : ssg_ctl_model

// file: tb_top.sv
// Self-checking bench for the fault and pulse guard.
`timescale 1ns/100ps
module tb_top;
   import ssg_pkg::*;
   localparam int unsigned Hold = 50;
   logic clock = 0, rst_n = 0, speedA = 0, speedB = 0, calibrated = 0;
   logic [7:0] monFire = 8'h00;
   logic [11:0] liveAmp = 12'h000, calAmp = 12'h000;
   ssg_proto_t protocol = SsgProtoSpeed;
   logic ctlReset, recalibrate, faultActive, outA, outB, faultHigh, faultSeen;
   int miscompares = 0, samplesChecked = 0;
   initial begin
      forever #2.5 clock = ~clock;
   end
   ssg_fault_guard #(.HOLD_CYC(Hold)) dut (.clock(clock), .rst_n(rst_n),
      .monFire(monFire), .protocol(protocol), .speedA(speedA),
      .speedB(speedB), .calibrated(calibrated), .liveAmp(liveAmp),
      .calAmp(calAmp), .ctlReset(ctlReset), .recalibrate(recalibrate),
      .faultActive(faultActive), .outA(outA), .outB(outB),
      .faultHigh(faultHigh));
   ssg_ctl_model #(.SEEN_CYC(Hold - 10)) ctl (.clock(clock), .rst_n(rst_n),
      .outA(outA), .outB(outB), .faultSeen(faultSeen));
   task automatic check(input string name, input logic [11:0] seen, exp);
      samplesChecked++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic giveVerdict;
      $display("miscompares %0d checked %0d", miscompares, samplesChecked);
      if (miscompares == 0 && samplesChecked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : giveVerdict
   task automatic cyc(input int n);
      repeat (n) @(negedge clock);
   endtask : cyc
   task automatic doReset;
      rst_n = 1'b0;
      cyc(12);
      rst_n = 1'b1;
   endtask : doReset
   task automatic faultRecov;
      int n;
      n = 0;
      monFire = 8'h01;
      cyc(2);
      monFire = 8'h00;
      check("faultOuts", {outA, outB, faultHigh}, 3'h7);
      check("ctlShort", faultSeen, 1'b0);
      while (ctlReset !== 1'b1 && n < 500) begin
         cyc(1);
         n++;
      end
      check("ctlRise", ctlReset, 1'b1);
      check("holdLong", n >= Hold - 2, 1'b1);
      check("ctlSeen", faultSeen, 1'b1);
      cyc(1);
      check("ctlPulse", ctlReset, 1'b0);
      cyc(2);
      check("faultEnd", faultActive, 1'b0);
   endtask : faultRecov
   task automatic monClass;
      for (int i = 0; i < 8; i++) begin
         doReset();
         monFire = 8'h01 << i;
         cyc(2);
         monFire = 8'h00;
         check("faultRaise", faultActive, 1'b1);
         cyc(Hold + 10);
         check("faultKept", faultActive, i > 3);
      end
      doReset();
   endtask : monClass
   task automatic recal;
      calibrated = 1'b1;
      calAmp = 12'h064;
      liveAmp = 12'h0c9;
      cyc(2);
      check("recalHigh", recalibrate, 1'b1);
      liveAmp = 12'h0c8;
      cyc(2);
      check("recalEdge", recalibrate, 1'b0);
   endtask : recal
   task automatic pulse;
      speedA = 1'b1;
      speedB = 1'b1;
      cyc(2);
      check("speedRise", {outA, outB}, 2'h3);
      speedA = 1'b0;
      speedB = 1'b0;
      cyc(2);
      check("speedFollow", {outA, outB}, 2'h0);
      protocol = SsgProtoPulse;
      cyc(210);
      speedA = 1'b1;
      speedB = 1'b1;
      cyc(2);
      check("pulseStart", {outA, outB}, 2'h3);
      speedA = 1'b0;
      speedB = 1'b0;
      cyc(10);
      check("pulseHeld", {outA, outB}, 2'h3);
      cyc(200);
      check("pulseDone", {outA, outB}, 2'h0);
      protocol = SsgProtoXor;
      speedA = 1'b1;
      speedB = 1'b1;
      cyc(2);
      check("xorFollow", {outA, outB}, 2'h3);
   endtask : pulse
   initial begin
      doReset();
      faultRecov();
      monClass();
      recal();
      pulse();
      giveVerdict();
   end
   initial begin
      #50000;
      miscompares++;
      giveVerdict();
   end
endmodule : tb_top
